// [src/line_loopback_activation_fsm.sv]
// Line-side loopback activation control state machine
// What this block does
// - Loopback request starts awake and training
// - Activating state sends awake and training
// - Awake acknowledgement enters activating, reports start
// - Stay activating until receiver synchronises
// - Synchronised: request loopback operation signal
// - Synchronised: report line active indication
// - Wait for far end loopback confirmation
// - Confirmation: loopback active, report it
// - Loopback active held until deactivation request
// - Deactivation: no-line, deactivate, timer, return
`timescale 1ns/100ps
`default_nettype none
module line_loopback_activation_fsm #(
  parameter int DEACT_CYCLES = loopback_pkg::DEACT_TIMER_CYCLES  // Deactivation timer length
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Requests from the exchange-side controller, same clock
  input  wire logic loopbackTwoRequest,
  input  wire logic deactivationRequest,
  // Events from the line, asynchronous
  input  wire logic awakeAckSignal,
  input  wire logic rxSynchronised,
  input  wire logic loopbackConfirmationSignal,
  // Signals sent toward the network-side terminal
  output logic      awakeSignal,
  output logic      outgoingTrainingSignal,
  output logic      loopbackOperationSignal,
  output logic      noLineSignal,
  output logic      lineDeactivateSignal,
  // Indications to the exchange-side controller, one-cycle pulses
  output logic      activationStartedIndication,
  output logic      lineActiveIndication,
  output logic      loopbackActiveIndication,
  output logic      deactivatedIndication
);

  // ==========================================================
  // Line input synchronisers
  // ==========================================================
  logic [2:0] syncFirst;   // First stage, read only by second
  logic [2:0] syncSecond;  // Second stage, safe to use

  // Two flip-flops on each line event
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      syncFirst  <= 3'h0;
      syncSecond <= 3'h0;
    end
    else
    begin
      syncFirst  <= {loopbackConfirmationSignal, rxSynchronised, awakeAckSignal};
      syncSecond <= syncFirst;
    end
  end

  logic awakeAck;   // Synchronised acknowledgement
  logic rxSync;     // Synchronised receiver lock
  logic loopConf;   // Synchronised loopback confirmation
  assign awakeAck = syncSecond[0];
  assign rxSync   = syncSecond[1];
  assign loopConf = syncSecond[2];

  // ==========================================================
  // State register
  // ==========================================================
  loopback_pkg::line_state_t state;       // Current state
  loopback_pkg::line_state_t next_state;  // Next state
  logic timerStart;                       // Start deactivation timer
  logic timerExpired;                     // Timer done

  // Next-state decode
  always_comb
  begin
    next_state = state;
    case (state)
      loopback_pkg::DEACTIVATED:
        if (loopbackTwoRequest)
          next_state = loopback_pkg::ACTIVATION_INIT;
      loopback_pkg::ACTIVATION_INIT:
        if (deactivationRequest)
          next_state = loopback_pkg::DEACTIVATING;
        else if (awakeAck)
          next_state = loopback_pkg::LOOPBACK_ACTIVATING;
      loopback_pkg::LOOPBACK_ACTIVATING:
        if (deactivationRequest)
          next_state = loopback_pkg::DEACTIVATING;
        else if (rxSync)
          next_state = loopback_pkg::LOOPBACK_REQUESTING;
      loopback_pkg::LOOPBACK_REQUESTING:
        if (deactivationRequest)
          next_state = loopback_pkg::DEACTIVATING;
        else if (loopConf)
          next_state = loopback_pkg::LOOPBACK_ACTIVE;
      loopback_pkg::LOOPBACK_ACTIVE:
        if (deactivationRequest)
          next_state = loopback_pkg::DEACTIVATING;
      loopback_pkg::DEACTIVATING:
        if (timerExpired)
          next_state = loopback_pkg::DEACTIVATED;
      default:
        next_state = loopback_pkg::DEACTIVATED;
    endcase
  end

  // State update
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state <= loopback_pkg::DEACTIVATED;
    else
      state <= next_state;
  end

  // Timer starts on entry to deactivating
  assign timerStart = (next_state == loopback_pkg::DEACTIVATING) &&
                      (state != loopback_pkg::DEACTIVATING);

  // ==========================================================
  // Deactivation timer
  // ==========================================================
  deact_timer #(
    .CYCLES (DEACT_CYCLES)
  ) u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (timerStart),
    .expired (timerExpired)
  );

  // ==========================================================
  // Line signals, registered from next state
  // ==========================================================
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      awakeSignal             <= 1'b0;
      outgoingTrainingSignal  <= 1'b0;
      loopbackOperationSignal <= 1'b0;
      noLineSignal            <= 1'b1;
      lineDeactivateSignal    <= 1'b1;
    end
    else
    begin
      // Awake and training while activating
      awakeSignal <= (next_state == loopback_pkg::ACTIVATION_INIT) ||
                     (next_state == loopback_pkg::LOOPBACK_ACTIVATING);
      outgoingTrainingSignal <= (next_state == loopback_pkg::ACTIVATION_INIT) ||
                                (next_state == loopback_pkg::LOOPBACK_ACTIVATING);
      // Loopback operation once requested and while active
      loopbackOperationSignal <= (next_state == loopback_pkg::LOOPBACK_REQUESTING) ||
                                 (next_state == loopback_pkg::LOOPBACK_ACTIVE);
      // No-line and deactivate while down
      noLineSignal <= (next_state == loopback_pkg::DEACTIVATING) ||
                      (next_state == loopback_pkg::DEACTIVATED);
      lineDeactivateSignal <= (next_state == loopback_pkg::DEACTIVATING) ||
                              (next_state == loopback_pkg::DEACTIVATED);
    end
  end

  // ==========================================================
  // Indications, one pulse on each of four forward transitions
  // ==========================================================
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      activationStartedIndication <= 1'b0;
      lineActiveIndication        <= 1'b0;
      loopbackActiveIndication    <= 1'b0;
      deactivatedIndication       <= 1'b0;
    end
    else
    begin
      activationStartedIndication <= (state == loopback_pkg::ACTIVATION_INIT) &&
                       (next_state == loopback_pkg::LOOPBACK_ACTIVATING);
      lineActiveIndication <= (state == loopback_pkg::LOOPBACK_ACTIVATING) &&
                       (next_state == loopback_pkg::LOOPBACK_REQUESTING);
      loopbackActiveIndication <= (state == loopback_pkg::LOOPBACK_REQUESTING) &&
                       (next_state == loopback_pkg::LOOPBACK_ACTIVE);
      deactivatedIndication <= (state == loopback_pkg::DEACTIVATING) &&
                       (next_state == loopback_pkg::DEACTIVATED);
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  request_starts_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state == loopback_pkg::DEACTIVATED && loopbackTwoRequest) |=>
      state == loopback_pkg::ACTIVATION_INIT && awakeSignal && outgoingTrainingSignal)
    else $error("loopback request did not start awake");
  activating_sends_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state == loopback_pkg::LOOPBACK_ACTIVATING) |-> awakeSignal && outgoingTrainingSignal)
    else $error("activating state not sending awake and training");
  ack_reports_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state == loopback_pkg::ACTIVATION_INIT && awakeAck && !deactivationRequest) |=>
      activationStartedIndication && state == loopback_pkg::LOOPBACK_ACTIVATING)
    else $error("acknowledgement not reported");
  wait_sync_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state == loopback_pkg::LOOPBACK_ACTIVATING && !rxSync && !deactivationRequest) |=>
      $stable(state))
    else $error("left activating without synchronisation");
  sync_request_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state == loopback_pkg::LOOPBACK_ACTIVATING && rxSync && !deactivationRequest) |=>
      loopbackOperationSignal && !awakeSignal)
    else $error("loopback operation not sent on sync");
  line_active_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(lineActiveIndication) |-> $past(state, 1) == loopback_pkg::LOOPBACK_ACTIVATING)
    else $error("line active indication without sync");
  wait_confirm_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state == loopback_pkg::LOOPBACK_ACTIVE) |-> $past(loopConf) ||
      $past(state) == loopback_pkg::LOOPBACK_ACTIVE)
    else $error("loopback active without confirmation");
  confirm_report_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state == loopback_pkg::LOOPBACK_REQUESTING && loopConf && !deactivationRequest) |=>
      loopbackActiveIndication ##1 !loopbackActiveIndication)
    else $error("loopback active not reported once");
  active_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state == loopback_pkg::LOOPBACK_ACTIVE && !deactivationRequest) |=>
      state == loopback_pkg::LOOPBACK_ACTIVE)
    else $error("loopback active left without deactivation");
  deact_signals_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state == loopback_pkg::LOOPBACK_ACTIVE && deactivationRequest) |=>
      noLineSignal && lineDeactivateSignal && state == loopback_pkg::DEACTIVATING)
    else $error("deactivation signals missing");
  idle_stays_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state == loopback_pkg::DEACTIVATED && !loopbackTwoRequest) |=>
      state == loopback_pkg::DEACTIVATED && noLineSignal)
    else $error("deactivated state changed without request");

endmodule : line_loopback_activation_fsm
`default_nettype wire

// [shared/loopback_pkg.sv]
// Shared constants and state type for the loopback activation control
package loopback_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int DEACT_TIMER_MS     = 40;                 // Deactivation timer length, ms
  localparam int CLK_HZ             = 50_000_000;         // System clock rate
  localparam int DEACT_TIMER_CYCLES = DEACT_TIMER_MS * (CLK_HZ / 1000); // Timer in cycles

  // ==========================================================
  // Control states, Gray coded along the usual path
  // ==========================================================
  typedef enum logic [2:0] {
    DEACTIVATED         = 3'h0,  // Access deactivated
    ACTIVATION_INIT     = 3'h1,  // Awake sent, waiting for acknowledgement
    LOOPBACK_ACTIVATING = 3'h3,  // Waiting for receiver synchronisation
    LOOPBACK_REQUESTING = 3'h2,  // Loopback requested, waiting confirmation
    LOOPBACK_ACTIVE     = 3'h6,  // Loopback established
    DEACTIVATING        = 3'h4   // Deactivation timer running
  } line_state_t;

endpackage : loopback_pkg

// [src/deact_timer.sv]
// Deactivation timer: counts down after a start pulse and flags expiry
`timescale 1ns/100ps
`default_nettype none
module deact_timer #(
  parameter int CYCLES = loopback_pkg::DEACT_TIMER_CYCLES  // Timer length in cycles
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Control
  input  wire logic start,
  output logic      expired
);

  // ==========================================================
  // Counter
  // ==========================================================
  logic [31:0] count;    // Remaining cycles
  logic        running;  // Timer active

  // Load on start, count down while running
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      count   <= 32'h0;
      running <= 1'b0;
      expired <= 1'b0;
    end
    else if (start)
    begin
      count   <= 32'(CYCLES - 1);
      running <= 1'b1;
      expired <= 1'b0;
    end
    else if (running)
    begin
      // Expiry pulses one cycle when the count runs out
      expired <= (count == 32'h1) || (count == 32'h0);
      running <= (count > 32'h1);
      if (count != 32'h0)
        count <= count - 32'h1;
    end
    else
      expired <= 1'b0;
  end

endmodule : deact_timer
`default_nettype wire

// [bench/far_end_model.sv]
// Behavioural model of the network-side terminal across the line
`timescale 1ns/100ps
`default_nettype none
module far_end_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Signals from the line-side terminal
  input  wire logic       awakeSignal,
  input  wire logic       outgoingTrainingSignal,
  input  wire logic       loopbackOperationSignal,
  input  wire logic       noLineSignal,
  // Bench controls: answer delay and stray events
  input  wire logic [3:0] lag,
  input  wire logic       spurious,
  // Events sent back to the line-side terminal
  output logic            awakeAckSignal,
  output logic            rxSynchronised,
  output logic            loopbackConfirmationSignal
);
  // ==========================================================
  // Answer sequencing
  // ==========================================================
  logic [3:0] waitCount;  // Cycles spent on the pending answer

  // One answer at a time, each after lag cycles; no line drops all unless spurious is set
  always_ff @(posedge sys_clk)
  begin
    if (rst || (noLineSignal && !spurious))
    begin
      waitCount                  <= 4'h0;
      awakeAckSignal             <= 1'b0;
      rxSynchronised             <= 1'b0;
      loopbackConfirmationSignal <= 1'b0;
    end
    else if (spurious)
    begin
      // Stray synchronisation and confirmation, no acknowledgement
      rxSynchronised             <= 1'b1;
      loopbackConfirmationSignal <= 1'b1;
    end
    else if (waitCount < lag)
      waitCount <= waitCount + 4'h1;
    else if (awakeSignal && !awakeAckSignal)
    begin
      awakeAckSignal <= 1'b1;
      waitCount      <= 4'h0;
    end
    else if (outgoingTrainingSignal && awakeAckSignal && !rxSynchronised)
    begin
      rxSynchronised <= 1'b1;
      waitCount      <= 4'h0;
    end
    else if (loopbackOperationSignal && !loopbackConfirmationSignal)
      loopbackConfirmationSignal <= 1'b1;
  end
endmodule : far_end_model
`default_nettype wire

// [bench/line_loopback_activation_fsm_tb.sv]
// Self-checking bench for the loopback activation control
`timescale 1ns/100ps
`default_nettype none
module line_loopback_activation_fsm_tb;
  // ==========================================================
  // Signals
  // ==========================================================
  localparam int DEACT = 10;               // Short timer for simulation
  logic       sys_clk = 1'b0;              // 50 MHz clock
  logic       rst = 1'b1;                  // Synchronous reset
  logic       loopbackTwoRequest = 1'b0;   // Exchange loopback request
  logic       deactivationRequest = 1'b0;  // Exchange deactivation request
  logic [3:0] lag = 4'h0;                  // Far-end answer delay
  logic       spurious = 1'b0;             // Stray far-end events
  logic       clrSeen = 1'b0;              // Clears indication record
  logic [7:0] seen;                        // Indications seen so far
  logic [3:0] live;                        // Indications in this cycle
  logic awakeAckSignal, rxSynchronised, loopbackConfirmationSignal, awakeSignal;
  logic outgoingTrainingSignal, loopbackOperationSignal, noLineSignal, lineDeactivateSignal;
  logic activationStartedIndication, lineActiveIndication, loopbackActiveIndication;
  logic deactivatedIndication;
  int   nMismatch = 0;                     // Mismatches found
  int   totalChecks = 0;                   // Comparisons made
  int   cnt;                               // Cycle counter

  // Row: answer delay, stage reached, line signals, indications
  typedef struct { logic [3:0] lag; int stage; logic [7:0] line; logic [7:0] ind; } row_t;
  row_t rows [5] = '{'{4'h8, 0, 8'h18, 8'h08}, '{4'h0, 1, 8'h18, 8'h09},
    '{4'h3, 2, 8'h04, 8'h0B}, '{4'h0, 3, 8'h04, 8'h0F}, '{4'h5, 3, 8'h04, 8'h0F}};

  // ==========================================================
  // Design, far end and clock
  // ==========================================================
  always #10 sys_clk = ~sys_clk;

  line_loopback_activation_fsm #(.DEACT_CYCLES(DEACT)) dut_u (.sys_clk(sys_clk), .rst(rst),
    .loopbackTwoRequest(loopbackTwoRequest), .deactivationRequest(deactivationRequest),
    .awakeAckSignal(awakeAckSignal), .rxSynchronised(rxSynchronised),
    .loopbackConfirmationSignal(loopbackConfirmationSignal), .awakeSignal(awakeSignal),
    .outgoingTrainingSignal(outgoingTrainingSignal),
    .loopbackOperationSignal(loopbackOperationSignal), .noLineSignal(noLineSignal),
    .lineDeactivateSignal(lineDeactivateSignal),
    .activationStartedIndication(activationStartedIndication),
    .lineActiveIndication(lineActiveIndication),
    .loopbackActiveIndication(loopbackActiveIndication),
    .deactivatedIndication(deactivatedIndication));

  far_end_model far_u (.sys_clk(sys_clk), .rst(rst), .awakeSignal(awakeSignal),
    .outgoingTrainingSignal(outgoingTrainingSignal),
    .loopbackOperationSignal(loopbackOperationSignal), .noLineSignal(noLineSignal),
    .lag(lag), .spurious(spurious), .awakeAckSignal(awakeAckSignal),
    .rxSynchronised(rxSynchronised), .loopbackConfirmationSignal(loopbackConfirmationSignal));

  // Indication pulses as they stand now
  assign live = {deactivatedIndication, loopbackActiveIndication, lineActiveIndication,
                 activationStartedIndication};

  // Record every indication pulse, one cycle behind live
  always @(posedge sys_clk)
    seen <= clrSeen ? 8'h00 : seen | {4'h0, live};

  // ==========================================================
  // Helpers
  // ==========================================================
  // All line signals, padded to the check width
  function automatic logic [7:0] lines();
    return {3'h0, awakeSignal, outgoingTrainingSignal, loopbackOperationSignal, noLineSignal,
            lineDeactivateSignal};
  endfunction : lines

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : tick

  task automatic giveVerdict();
    if (nMismatch == 0 && totalChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : giveVerdict

  // Cuts a hang short
  initial
  begin
    #(20 * 20000);
    nMismatch++;
    giveVerdict();
  end

  // ==========================================================
  // Scenarios
  // ==========================================================
  initial
  begin
    tick(3);
    rst = 1'b0;
    check(lines(), 8'h03);
    foreach (rows[i])
    begin
      lag = rows[i].lag;
      clrSeen = 1'b1;
      loopbackTwoRequest = 1'b1;
      tick(1);
      clrSeen = 1'b0;
      loopbackTwoRequest = 1'b0;
      // Stop in the very cycle in which the row's stage is entered
      for (cnt = 0; cnt < 100 && (rows[i].stage == 0 ? !awakeSignal : !live[rows[i].stage - 1]);
           cnt++)
        tick(1);
      check({7'h0, cnt < 100}, 8'h01);
      check(lines(), rows[i].line);
      if (rows[i].stage == 3)
      begin
        tick(20);
        check(lines(), rows[i].line);
      end
      deactivationRequest = 1'b1;
      tick(1);
      deactivationRequest = 1'b0;
      check(lines(), 8'h03);
      for (cnt = 0; cnt < DEACT + 20 && !seen[3]; cnt++)
        tick(1);
      // Timer span plus the one-cycle lag of the record
      check({7'h0, cnt == DEACT + 1}, 8'h01);
      check(seen, rows[i].ind);
      tick(4);
    end
    // Stray line events and deactivation request while deactivated
    spurious = 1'b1;
    deactivationRequest = 1'b1;
    clrSeen = 1'b1;
    tick(8);
    clrSeen = 1'b0;
    deactivationRequest = 1'b0;
    check(lines(), 8'h03);
    spurious = 1'b0;
    tick(12);
    check(seen, 8'h00);
    // Reset in mid-activation returns to the deactivated outputs
    lag = 4'h2;
    loopbackTwoRequest = 1'b1;
    tick(1);
    loopbackTwoRequest = 1'b0;
    tick(6);
    rst = 1'b1;
    clrSeen = 1'b1;
    tick(3);
    rst = 1'b0;
    clrSeen = 1'b0;
    check(lines(), 8'h03);
    // No stray step or pulse in the first cycles after release
    tick(2);
    check(lines(), 8'h03);
    check(seen, 8'h00);
    giveVerdict();
  end
endmodule : line_loopback_activation_fsm_tb
`default_nettype wire
